// File: hdl/fedb_pkg.sv
// Shared constants and state type of the dead-band stage.
// Assumes one generator clock drives every user of this package.
package fedb_pkg;
   localparam int unsigned CNT_W  = 6;   // Width of each dead-band counter
   localparam int unsigned SET_W  = 7;   // Width of a count setting, 0..64
   localparam logic [6:0]  DB_MAX = 7'h40; // Longest dead band in counts
   localparam logic [5:0]  CNT_RST = 6'h00; // Counter value at each edge
   localparam logic [6:0]  AGE_MAX = 7'h7F; // Saturation of edge-age helper

   typedef enum logic [2:0] {
      ST_OFF,
      ST_HIGH,
      ST_RISE_WAIT,
      ST_LOW,
      ST_FALL_WAIT
   } fedb_state_t;
endpackage

// File: hdl/fedb_top.sv
// Complementary output stage with rising and falling dead-band timing.
// Assumes source_in and both count settings come from logic on mclk_in
// and that the settings are held stable while an interval is timed.
`timescale 1ns/1ps

// Overview of operation
// - A falling source edge turns the primary off and starts the interval.
// - The complementary output turns on only once the interval has run out.
// - The falling interval length is a count setting of 0 to 64 counts.
// - A falling count of zero turns the complementary output on at once.
// - Timing starts at the source edge itself, not at an output change.
// - A source change before the count ends keeps the waiting output off.
// - The interval counts clock periods upward from zero to one below the set value.
// - Two separate six-bit counters serve rising and falling source edges.
module fedb_top (
   input  wire logic       mclk_in,
   input  wire logic       rst_b_in,
   input  wire logic       source_in,
   input  wire logic [6:0] rising_deadband_count_in,
   input  wire logic [6:0] falling_deadband_count_in,
   output logic            primary_output_out,
   output logic            complementary_output_out
);

   // One clock, one reset: every check in this module shares them
   default clocking cb_fedb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_b_in);

   // Settings above 64 saturate; returns the last counter index, N-1
   function automatic logic [5:0] last_index(input logic [6:0] setting);
      logic [6:0] eff;
      eff = (setting > fedb_pkg::DB_MAX) ? fedb_pkg::DB_MAX : setting;
      last_index = 6'(eff - 7'h01);
   endfunction

   function automatic logic [6:0] eff_count(input logic [6:0] setting);
      eff_count = (setting > fedb_pkg::DB_MAX) ? fedb_pkg::DB_MAX : setting;
   endfunction

   fedb_pkg::fedb_state_t state_q, state_d;
   logic       src_q,  src_d;
   logic       prim_q, prim_d;
   logic       comp_q, comp_d;
   logic [5:0] cnt_r_q, cnt_r_d;
   logic [5:0] cnt_f_q, cnt_f_d;
   logic       rise, fall;
   logic [6:0] eff_r, eff_f;
   logic [5:0] last_r, last_f;

   // Edges seen against last cycle's source; outputs lag by one register
   assign rise   = source_in & ~src_q;
   assign fall   = ~source_in & src_q;
   assign eff_r  = eff_count(rising_deadband_count_in);
   assign eff_f  = eff_count(falling_deadband_count_in);
   assign last_r = last_index(rising_deadband_count_in);
   assign last_f = last_index(falling_deadband_count_in);

   always_comb begin
      state_d = state_q;
      src_d   = source_in;
      prim_d  = prim_q;
      comp_d  = comp_q;
      cnt_r_d = cnt_r_q;
      cnt_f_d = cnt_f_q;
      if (fall) begin
         prim_d  = 1'b0;
         comp_d  = 1'b0;
         cnt_f_d = fedb_pkg::CNT_RST;
         if (eff_f == 7'h00) begin
            comp_d  = 1'b1;
            state_d = fedb_pkg::ST_LOW;
         end else begin
            state_d = fedb_pkg::ST_FALL_WAIT;
         end
      end else if (rise) begin
         // Same sequence on the rising counter; aborts any falling wait
         comp_d  = 1'b0;
         prim_d  = 1'b0;
         cnt_r_d = fedb_pkg::CNT_RST;
         if (eff_r == 7'h00) begin
            prim_d  = 1'b1;
            state_d = fedb_pkg::ST_HIGH;
         end else begin
            state_d = fedb_pkg::ST_RISE_WAIT;
         end
      end else begin
         unique case (state_q)
            fedb_pkg::ST_FALL_WAIT: begin
               if (cnt_f_q == last_f) begin
                  comp_d  = 1'b1;
                  state_d = fedb_pkg::ST_LOW;
               end else begin
                  cnt_f_d = 6'(cnt_f_q + 6'h01);
               end
            end
            fedb_pkg::ST_RISE_WAIT: begin
               if (cnt_r_q == last_r) begin
                  prim_d  = 1'b1;
                  state_d = fedb_pkg::ST_HIGH;
               end else begin
                  cnt_r_d = 6'(cnt_r_q + 6'h01);
               end
            end
            fedb_pkg::ST_OFF,
            fedb_pkg::ST_HIGH,
            fedb_pkg::ST_LOW: begin
               state_d = state_q;
            end
         endcase
      end
   end

   // Both outputs start off; the first source edge sets the phase
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= fedb_pkg::ST_OFF;
         src_q   <= 1'b0;
         prim_q  <= 1'b0;
         comp_q  <= 1'b0;
         cnt_r_q <= fedb_pkg::CNT_RST;
         cnt_f_q <= fedb_pkg::CNT_RST;
      end else begin
         state_q <= state_d;
         src_q   <= src_d;
         prim_q  <= prim_d;
         comp_q  <= comp_d;
         cnt_r_q <= cnt_r_d;
         cnt_f_q <= cnt_f_d;
      end
   end

   assign primary_output_out       = prim_q;
   assign complementary_output_out = comp_q;

   // Checking helpers: cycles since the latest edge of each kind
   logic [6:0] age_f_q, age_f_d;
   logic [6:0] age_r_q, age_r_d;

   always_comb begin
      age_f_d = fall ? 7'h00 : ((age_f_q == fedb_pkg::AGE_MAX) ? age_f_q
                                : 7'(age_f_q + 7'h01));
      age_r_d = rise ? 7'h00 : ((age_r_q == fedb_pkg::AGE_MAX) ? age_r_q
                                : 7'(age_r_q + 7'h01));
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         age_f_q <= fedb_pkg::AGE_MAX;
         age_r_q <= fedb_pkg::AGE_MAX;
      end else begin
         age_f_q <= age_f_d;
         age_r_q <= age_r_d;
      end
   end

   sequence s_fall_zero;
      fall && (eff_f == 7'h00);
   endsequence

   sequence s_fall_timed;
      fall && (eff_f != 7'h00);
   endsequence

   sequence s_rise_timed;
      rise && (eff_r != 7'h00);
   endsequence

   // A zero band may raise the other output in the same cycle
   a_fall_prim_off: assert property (fall |=> !primary_output_out)
      else $error("primary output not off after falling edge");

   a_prim_hold: assert property (
      primary_output_out && !fall |=> primary_output_out)
      else $error("primary output dropped without falling edge");

   a_no_overlap: assert property (
      !(primary_output_out && complementary_output_out))
      else $error("outputs on together");

   a_comp_delay: assert property (
      $rose(complementary_output_out) |-> age_f_q == eff_f)
      else $error("complementary output turned on at wrong count");

   a_wait_comp_off: assert property (
      (state_q == fedb_pkg::ST_FALL_WAIT) |-> !complementary_output_out)
      else $error("complementary output on during falling interval");

   a_comp_hold: assert property (
      complementary_output_out && !rise |=> complementary_output_out)
      else $error("complementary output dropped without rising edge");

   a_zero_band: assert property (
      s_fall_zero |=> complementary_output_out)
      else $error("zero dead band not immediate");

   a_from_edge: assert property (
      s_fall_timed |=> !complementary_output_out
         ##0 (state_q == fedb_pkg::ST_FALL_WAIT))
      else $error("falling interval not started at edge");

   a_abort_hold: assert property (
      (state_q == fedb_pkg::ST_FALL_WAIT) && rise
         |=> !complementary_output_out [*2])
      else $error("aborted phase output turned on");

   a_count_step: assert property (
      (state_q == fedb_pkg::ST_FALL_WAIT) && !rise && !fall
         && (cnt_f_q != last_f)
         |=> cnt_f_q == 6'($past(cnt_f_q) + 6'h01))
      else $error("falling counter did not step up");

   a_rise_delay: assert property (
      $rose(primary_output_out) |-> age_r_q == eff_r)
      else $error("primary output turned on at wrong count");

   a_rise_comp_off: assert property (
      rise |=> !complementary_output_out)
      else $error("complementary output not off after rising edge");

   a_wait_prim_off: assert property (
      (state_q == fedb_pkg::ST_RISE_WAIT) |-> !primary_output_out)
      else $error("primary output on during rising interval");

   a_fall_clear: assert property (s_fall_timed |=> cnt_f_q == 6'h00)
      else $error("falling counter not cleared at edge");

   a_rise_clear: assert property (s_rise_timed |=> cnt_r_q == 6'h00)
      else $error("rising counter not cleared at edge");

endmodule // fedb_top

// File: tb/fedb_switch_model.sv
// Model of the two power switch drivers fed by the stage outputs.
// Assumes both gate lines are registered on mclk_in.
`timescale 1ns/1ps
module fedb_switch_model (
   input  wire logic mclk_in,
   input  wire logic hi_gate_in,
   input  wire logic lo_gate_in,
   output logic      shoot_out
);
   // Sticky, so a single overlapping cycle is not lost
   logic shoot_q = 1'b0;
   always @(posedge mclk_in) begin
      if (hi_gate_in && lo_gate_in) shoot_q <= 1'b1;
   end
   assign shoot_out = shoot_q;
endmodule // fedb_switch_model

// File: tb/tb.sv
// Self-checking bench of the dead-band stage.
// Assumes outputs settle within 1 ns of the rising clock edge.
`timescale 1ns/1ps
module tb;
   logic       mclk_in;
   logic       rst_b_in;
   logic       src;
   logic       shoot;
   logic       pri;
   logic       cmp;
   logic [6:0] rdb;
   logic [6:0] fdb;
   int         err_count = 0;
   int         tests_run = 0;
   int         cyc       = 0;

   fedb_top u_fedb_top (
      .mclk_in                   (mclk_in),
      .rst_b_in                  (rst_b_in),
      .source_in                 (src),
      .rising_deadband_count_in  (rdb),
      .falling_deadband_count_in (fdb),
      .primary_output_out        (pri),
      .complementary_output_out  (cmp)
   );
   fedb_switch_model u_fedb_switch_model (
      .mclk_in    (mclk_in),
      .hi_gate_in (pri),
      .lo_gate_in (cmp),
      .shoot_out  (shoot)
   );

   initial mclk_in = 1'b0;
   always #4 mclk_in = ~mclk_in;

   task automatic print_verdict();
      if (err_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // One source edge to level v with count n; ab > 0 flips source back early
   task automatic edge_seq(input logic v, input logic [6:0] n, input int ab);
      int e;
      e = (n > 7'h40) ? 64 : int'(n);
      @(posedge mclk_in);
      #1;
      if (v) rdb = n;
      else fdb = n;
      src = v;
      for (int k = 0; k <= e + 1; k++) begin
         @(posedge mclk_in);
         #1;
         if (k == ab && ab > 0) src = ~v;
         // Pass k follows the edge that saw the source change by k cycles
         if (ab == 0 || k <= ab)
            chk("off side", 1'b0, v ? cmp : pri);
         chk("on side", (ab == 0) && (k >= e), v ? pri : cmp);
      end
   endtask

   // Short rising band, then zero bands on both edges
   task automatic test_short_bands();
      edge_seq(1'b1, 7'h03, 0);
      edge_seq(1'b0, 7'h00, 0);
      edge_seq(1'b1, 7'h00, 0);
   endtask

   task automatic test_timed_bands();
      edge_seq(1'b0, 7'h05, 0);
      edge_seq(1'b1, 7'h07, 0);
   endtask

   // Full range, then a setting above it that must saturate
   task automatic test_band_limits();
      edge_seq(1'b0, 7'h40, 0);
      edge_seq(1'b1, 7'h02, 0);
      edge_seq(1'b0, 7'h64, 0);
      edge_seq(1'b1, 7'h01, 0);
   endtask

   // Source flips back mid-band; the next edge restarts from zero
   task automatic test_early_change();
      edge_seq(1'b0, 7'h0A, 4);
      edge_seq(1'b0, 7'h06, 0);
      edge_seq(1'b1, 7'h09, 3);
      edge_seq(1'b1, 7'h02, 0);
   endtask

   initial begin
      rst_b_in = 1'b0;
      src      = 1'b0;
      rdb      = 7'h00;
      fdb      = 7'h00;
      repeat (4) @(posedge mclk_in);
      #1;
      rst_b_in = 1'b1;
      chk("reset primary", 1'b0, pri);
      chk("reset comp", 1'b0, cmp);
      test_short_bands();
      test_timed_bands();
      test_band_limits();
      test_early_change();
      chk("overlap", 1'b0, shoot);
      print_verdict();
   end

   // Whole run needs about 220 cycles
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 1000) begin
         err_count++;
         print_verdict();
      end
   end
endmodule // tb
